// ---- verilog/msq_top.sv ----
// Function
// RULE_01: Lower eight outputs driven, never floating, except bits 7,6 under the diagnostic option
// RULE_02: Diagnostic option: bits 7,6 become inputs
// RULE_03: Reset low forces next address 63
// RULE_04: Reset edge loads 63, word, clears match
// RULE_05: Reset leaves loop counter, return address alone
// RULE_06: Each of six tests selectable by field
// RULE_07: Tests usable as branch target or count
// RULE_08: Count-zero pin low when counter zero
// RULE_09: Diagnostic mode: zero pin carries serial data
// RULE_10: One edge updates all sequencer state together
// RULE_11: Select value six tests external condition
// RULE_12: Upper outputs enabled by pipeline enable bit
// RULE_13: Held reset reloads address 63 each edge
// RULE_14: Surrounding logic keeps inputs clock-synchronous
module msq_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Device pins
  input wire logic reset_n_i,
  input wire logic [5:0] test_i,
  input wire logic external_condition_i,
  input wire logic shadow_shift_clock_i,
  input wire logic diag_mode_i,
  output logic [7:0] p_hi_o,
  output logic p_hi_oe_o,
  output logic [7:0] p_lo_o,
  output logic [7:0] p_lo_oe_o,
  output logic zero_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import msq_pkg::*;

  // ****************************************
  // State
  // ****************************************
  // Microprogram store has no reset; software loads it before use
  logic [31:0] rom_q [MSQ_DEPTH];
  logic [5:0] pc_q, pc_d, loop_counter_q, loop_counter_d;
  logic [5:0] return_address_reg_q, return_address_reg_d;
  logic [31:0] pipe_q, pipe_d;
  logic match_flag_q, match_flag_d;
  logic shadow_diag_option_q, shadow_diag_option_d;
  logic [5:0] uaddr_q, uaddr_d;
  logic [31:0] shadow_q, shadow_d;
  logic sclk_q, sclk_d;
  logic [31:0] rdat_d;
  logic ack_d, rom_we;
  logic [5:0] next_address_select;
  logic cond, sel_bit;
  msq_op_t op;
  msq_pins_t pins_d, pins_q;
  logic [7:0] lo_oe_q, lo_oe_d;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    op = msq_op_t'(pipe_q[MSQ_OP_LSB +: 4]);
    // Select values 6 and 7 bypass the test inputs
    case (pipe_q[MSQ_TEST_LSB +: 3])
      MSQ_TEST_EXT: sel_bit = external_condition_i; // RULE_11 RULE_14
      MSQ_TEST_ALWAYS: sel_bit = 1'b1;
      default: sel_bit = test_i[pipe_q[MSQ_TEST_LSB +: 3]]; // RULE_06
    endcase
    cond = sel_bit ^ pipe_q[MSQ_POL_BIT];
    next_address_select = pc_q;
    loop_counter_d = loop_counter_q;
    return_address_reg_d = return_address_reg_q;
    case (op)
      MSQ_OP_JMP_DATA: if (cond) begin
        next_address_select = pipe_q[MSQ_DATA_LSB +: 6];
      end
      MSQ_OP_JMP_T: if (cond) begin
        next_address_select = test_i; // RULE_07
      end
      MSQ_OP_LDC_DATA: loop_counter_d = pipe_q[MSQ_DATA_LSB +: 6];
      MSQ_OP_LDC_T: loop_counter_d = test_i; // RULE_07
      MSQ_OP_LOOP: if (loop_counter_q != MSQ_ZERO6 && !cond) begin
        loop_counter_d = loop_counter_q - MSQ_ONE6;
        next_address_select = pipe_q[MSQ_DATA_LSB +: 6];
      end
      MSQ_OP_CALL: if (cond) begin
        return_address_reg_d = pc_q;
        next_address_select = pipe_q[MSQ_DATA_LSB +: 6];
      end
      MSQ_OP_RET: if (cond) begin
        next_address_select = return_address_reg_q;
      end
      default: next_address_select = pc_q;
    endcase
    // Counter and return register deliberately untouched by reset
    if (!reset_n_i) begin
      next_address_select = MSQ_TOP_ADDR; // RULE_03 RULE_05
    end
    // Sequential address wraps from 63 to 0
    pc_d = next_address_select + MSQ_ONE6;
    match_flag_d = (loop_counter_d == MSQ_ZERO6);
    if (!reset_n_i) begin
      pc_d = MSQ_TOP_ADDR; // RULE_04 RULE_13
      match_flag_d = 1'b0; // RULE_04
    end
    pipe_d = rom_q[next_address_select];
    // Diagnostic: shift shadow on rising shift clock, mode 1 loads pipeline
    shadow_d = shadow_q;
    sclk_d = shadow_shift_clock_i;
    if (shadow_diag_option_q && shadow_shift_clock_i && !sclk_q) begin // RULE_02
      if (!diag_mode_i) begin
        shadow_d = {shadow_q[30:0], external_condition_i}; // RULE_11
      end else if (reset_n_i) begin
        // Held reset wins over a diagnostic load
        pipe_d = shadow_q;
      end
    end
    pins_d.hi = pipe_d[15:8];
    pins_d.hi_oe = pipe_d[MSQ_OE_BIT]; // RULE_12
    pins_d.lo = pipe_d[7:0]; // RULE_01
    // Zero detect keeps running internally; only the pin changes
    pins_d.zero_pin = shadow_diag_option_q ? shadow_d[31] : (loop_counter_d != MSQ_ZERO6); // RULE_08 RULE_09
  end

  // ****************************************
  // Wishbone registers
  // ****************************************
  always_comb begin
    shadow_diag_option_d = shadow_diag_option_q;
    uaddr_d = uaddr_q;
    rom_we = 1'b0;
    // Registered ack: one wait state, then a one-cycle pulse
    ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
    rdat_d = 32'h00000000;
    // Status is read-only; a write to it is acknowledged and dropped
    if (ack_d && wb_we_i) begin
      case (wb_adr_i)
        MSQ_REG_CTRL: if (wb_sel_i[0]) begin
          shadow_diag_option_d = wb_dat_i[MSQ_CTRL_DIAG_BIT];
        end
        MSQ_REG_UADDR: if (wb_sel_i[0]) begin
          uaddr_d = wb_dat_i[5:0];
        end
        MSQ_REG_UDATA: rom_we = (wb_sel_i == 4'hF);
        default: rom_we = 1'b0;
      endcase
    end else if (ack_d) begin
      case (wb_adr_i)
        MSQ_REG_CTRL: rdat_d = {31'h0, shadow_diag_option_q};
        MSQ_REG_STATUS: begin
          rdat_d[MSQ_STAT_PC_LSB +: 6] = pc_q;
          rdat_d[MSQ_STAT_CNT_LSB +: 6] = loop_counter_q;
          rdat_d[MSQ_STAT_RET_LSB +: 6] = return_address_reg_q;
          rdat_d[MSQ_STAT_MATCH_BIT] = match_flag_q;
        end
        MSQ_REG_UADDR: rdat_d = {26'h0, uaddr_q};
        MSQ_REG_UDATA: rdat_d = rom_q[uaddr_q];
        default: rdat_d = 32'h00000000;
      endcase
    end
    // Bits 7 and 6 turn into inputs while the diagnostic option is on
    lo_oe_d = shadow_diag_option_d ? 8'h3F : 8'hFF; // RULE_01 RULE_02
  end

  // Write lands on the edge that raises ack
  always_ff @(posedge clk_i) begin
    if (rom_we) begin
      rom_q[uaddr_q] <= wb_dat_i;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    loop_counter_q <= loop_counter_d; // RULE_10
    return_address_reg_q <= return_address_reg_d;
    if (rst_i) begin
      pc_q <= MSQ_TOP_ADDR;
      pipe_q <= MSQ_CTRL_RESET;
      match_flag_q <= 1'b0;
      shadow_q <= MSQ_CTRL_RESET;
      sclk_q <= 1'b0;
      shadow_diag_option_q <= 1'b0;
      uaddr_q <= MSQ_ZERO6;
      pins_q <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      pc_q <= pc_d; // RULE_10
      pipe_q <= pipe_d;
      match_flag_q <= match_flag_d;
      shadow_q <= shadow_d;
      sclk_q <= sclk_d;
      shadow_diag_option_q <= shadow_diag_option_d;
      uaddr_q <= uaddr_d;
      pins_q <= pins_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  // Lower enables are a flop so pins stay registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_oe_q <= 8'hFF;
    end else begin
      lo_oe_q <= lo_oe_d;
    end
  end

  assign p_hi_o = pins_q.hi;
  assign p_hi_oe_o = pins_q.hi_oe;
  assign p_lo_o = pins_q.lo;
  assign p_lo_oe_o = lo_oe_q;
  assign zero_o = pins_q.zero_pin;

endmodule // msq_top

// ---- verilog/msq_pkg.sv ----
package msq_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned MSQ_AW = 6;
  localparam int unsigned MSQ_DEPTH = 64;
  localparam logic [5:0] MSQ_TOP_ADDR = 6'h3F;
  localparam logic [5:0] MSQ_ZERO6 = 6'h00;
  localparam logic [5:0] MSQ_ONE6 = 6'h01;

  // ****************************************
  // Microword fields (32 bits)
  // ****************************************
  localparam int unsigned MSQ_OP_LSB = 26;
  localparam int unsigned MSQ_TEST_LSB = 22;
  localparam int unsigned MSQ_POL_BIT = 25;
  localparam int unsigned MSQ_OE_BIT = 21;
  localparam int unsigned MSQ_DATA_LSB = 16;
  localparam logic [2:0] MSQ_TEST_EXT = 3'h6;
  localparam logic [2:0] MSQ_TEST_ALWAYS = 3'h7;

  // ****************************************
  // Wishbone register map (byte addresses)
  // ****************************************
  localparam logic [7:0] MSQ_REG_CTRL = 8'h00;
  localparam logic [7:0] MSQ_REG_STATUS = 8'h04;
  localparam logic [7:0] MSQ_REG_UADDR = 8'h08;
  localparam logic [7:0] MSQ_REG_UDATA = 8'h0C;
  localparam int unsigned MSQ_CTRL_DIAG_BIT = 0;
  localparam logic [31:0] MSQ_CTRL_RESET = 32'h00000000;
  localparam int unsigned MSQ_STAT_PC_LSB = 0;
  localparam int unsigned MSQ_STAT_CNT_LSB = 8;
  localparam int unsigned MSQ_STAT_RET_LSB = 16;
  localparam int unsigned MSQ_STAT_MATCH_BIT = 23;

  // ****************************************
  // Opcodes (our own encoding)
  // ****************************************
  typedef enum logic [3:0] {
    MSQ_OP_CONT = 4'h0,
    MSQ_OP_JMP_DATA = 4'h1,
    MSQ_OP_JMP_T = 4'h2,
    MSQ_OP_LDC_DATA = 4'h3,
    MSQ_OP_LDC_T = 4'h4,
    MSQ_OP_LOOP = 4'h5,
    MSQ_OP_CALL = 4'h6,
    MSQ_OP_RET = 4'h7
  } msq_op_t;

  typedef struct packed {
    logic [7:0] hi;
    logic hi_oe;
    logic [7:0] lo;
    logic zero_pin;
  } msq_pins_t;

endpackage : msq_pkg

// ---- verification/msq_cond_src.sv ----
module msq_cond_src (
  // Clock
  input wire logic clk_i,
  // Levels asked for by the bench
  input wire logic [5:0] t_req_i,
  input wire logic ext_req_i,
  // Toward the sequencer
  output logic [5:0] test_o,
  output logic ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Launched on the edge so the sampled level never races the sequencer
  always_ff @(posedge clk_i) begin
    test_o <= t_req_i;
    ext_o <= ext_req_i;
  end
endmodule // msq_cond_src

// ---- verification/msq_monitor.sv ----
module msq_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic reset_n_i,
  input wire logic [7:0] p_hi_o,
  input wire logic [7:0] p_lo_oe_o,
  input wire logic zero_o,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Pins
  // ****************************************
  lo_drive_a: assert property (p_lo_oe_o[5:0] == 6'h3F)
    else $error("lower outputs not driven");
  diag_oe_a: assert property (p_lo_oe_o == 8'hFF || p_lo_oe_o == 8'h3F)
    else $error("lower enable pattern wrong");
  held_reset_a: assert property (!reset_n_i [*3] |=> $stable(p_hi_o))
    else $error("upper outputs moved in held reset");
  reset_out_a: assert property ($fell(rst_i) |-> p_lo_oe_o == 8'hFF && !zero_o)
    else $error("outputs wrong after reset");
  // ****************************************
  // Bus
  // ****************************************
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  cover property (wb_ack_o && wb_we_i);
  cover property (p_lo_oe_o == 8'h3F);
  cover property (!reset_n_i [*3]);
endmodule // msq_monitor

bind msq_top msq_monitor msq_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .reset_n_i(reset_n_i), .p_hi_o(p_hi_o), .p_lo_oe_o(p_lo_oe_o), .zero_o(zero_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ---- verification/test_microsequencer_pin_control.sv ----
module test_microsequencer_pin_control import msq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, reset_n_i = 1, ext_q = 1, cyc = 0, stb = 0, we = 0, ext_w;
  logic sclk = 0, mode = 0;
  logic [5:0] t_q = 6'h05, test_w;
  logic [7:0] adr = 0, p_hi_o, p_lo_o, p_lo_oe_o;
  logic [31:0] dat = 0, rd, dat_o;
  logic p_hi_oe_o, zero_o, ack;
  int err_count = 0, tests_run = 0, cyc_n = 0;
  always #20 clk_i = ~clk_i;
  msq_cond_src msq_cond_src_inst (.clk_i(clk_i), .t_req_i(t_q), .ext_req_i(ext_q),
    .test_o(test_w), .ext_o(ext_w));
  msq_top msq_top_inst (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .test_i(test_w),
    .external_condition_i(ext_w), .shadow_shift_clock_i(sclk), .diag_mode_i(mode),
    .p_hi_o(p_hi_o), .p_hi_oe_o(p_hi_oe_o), .p_lo_o(p_lo_o), .p_lo_oe_o(p_lo_oe_o),
    .zero_o(zero_o), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  task print_verdict();
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      err_count++;
      print_verdict();
    end
  end
  function automatic logic [31:0] uw(logic [3:0] op, logic [2:0] s, logic [5:0] d,
                                     logic [15:0] o);
    return {2'h0, op, 1'h0, s, d, o};
  endfunction
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task rom(input logic [5:0] a, input logic [31:0] w);
    bus(1, MSQ_REG_UADDR, {26'h0, a});
    bus(1, MSQ_REG_UDATA, w);
  endtask
  task shift(input int n);
    repeat (n) begin
      sclk <= 1;
      @(posedge clk_i);
      sclk <= 0;
      @(posedge clk_i);
    end
  endtask
  // Reset pulse, then the path through the branch at word 6
  task run(input logic [2:0] s, input logic [7:0] e, input logic z);
    rom(6'h06, uw(MSQ_OP_JMP_DATA, s, 6'h08, 16'h0066));
    @(posedge clk_i);
    reset_n_i <= 0;
    repeat (3) @(posedge clk_i);
    chk("hi", 8'hA5, p_hi_o);
    chk("lo", 8'h5A, p_lo_o);
    chk("hi_oe", 8'h01, {7'h0, p_hi_oe_o});
    reset_n_i <= 1;
    repeat (12) @(posedge clk_i);
    chk("path", e, p_lo_o);
    chk("zero", {7'h0, z}, {7'h0, zero_o});
    chk("hi_off", 8'h00, {7'h0, p_hi_oe_o});
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rom(6'h3F, uw(MSQ_OP_CONT, 3'h0, 6'h20, 16'hA55A));
    rom(6'h00, uw(MSQ_OP_JMP_T, MSQ_TEST_ALWAYS, 6'h00, 16'h0011));
    rom(6'h05, uw(MSQ_OP_LDC_T, MSQ_TEST_ALWAYS, 6'h00, 16'h0022));
    rom(6'h07, uw(MSQ_OP_JMP_DATA, MSQ_TEST_ALWAYS, 6'h07, 16'h0077));
    rom(6'h08, uw(MSQ_OP_JMP_DATA, MSQ_TEST_ALWAYS, 6'h08, 16'h0088));
    for (int s = 0; s < 7; s++) begin
      run(3'(s), (s == 6 || t_q[s]) ? 8'h88 : 8'h77, 1'b1);
    end
    ext_q <= 0;
    rom(6'h05, uw(MSQ_OP_LDC_DATA, MSQ_TEST_ALWAYS, 6'h00, 16'h0022));
    run(MSQ_TEST_EXT, 8'h77, 1'b0);
    ext_q <= 1;
    bus(1, MSQ_REG_CTRL, 32'h00000001);
    repeat (2) @(posedge clk_i);
    chk("diag_oe", 8'h3F, p_lo_oe_o);
    shift(31);
    chk("sdo_31", 8'h00, {7'h0, zero_o});
    shift(1);
    chk("sdo_32", 8'h01, {7'h0, zero_o});
    bus(0, MSQ_REG_STATUS, 32'h00000000);
    chk("match", 8'h01, {7'h0, rd[MSQ_STAT_MATCH_BIT]});
    mode <= 1;
    shift(1);
    mode <= 0;
    chk("diag_load", 8'hFF, p_lo_o);
    bus(1, MSQ_REG_CTRL, 32'h00000000);
    repeat (2) @(posedge clk_i);
    chk("lo_oe", 8'hFF, p_lo_oe_o);
    chk("zero_pin", 8'h00, {7'h0, zero_o});
    bus(0, 8'h10, 32'h00000000);
    chk("unmapped", 8'h00, rd[7:0]);
    print_verdict();
  end
endmodule // test_microsequencer_pin_control
